// ---- rtl/spre_defines.svh ----
// constants for the scripted pulse-width ramp engine
`ifndef SPRE_DEFINES_SVH
`define SPRE_DEFINES_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SPRE_NCH        3
`define SPRE_FDEPTH     64
// ----------------------------------------------------------------
// host register offsets
// ----------------------------------------------------------------
`define SPRE_REG_ADDR   8'h00
`define SPRE_REG_WORD   8'h04
`define SPRE_REG_CTRL   8'h08
`define SPRE_REG_STAT   8'h0C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPRE_ADR_CH     8
`define SPRE_CTL_LAUNCH 2
`define SPRE_CTL_HALT   3
`define SPRE_CTL_RIRQ   4
`define SPRE_CTL_START  8
`define SPRE_ST_IRQ     4
`define SPRE_ST_RIRQ    8
// ----------------------------------------------------------------
// timing and values
// ----------------------------------------------------------------
`define SPRE_DIV_LO     16
`define SPRE_DIV_HI     512
`define SPRE_BR_LAST    6'h3B
`define SPRE_RAMP_RST   8'h00
`define SPRE_FULL       8'hFF
`define SPRE_EMPTY      8'h00
`endif

// ---- rtl/spre_pkg.sv ----
// types of the scripted pulse-width ramp engine
package spre_pkg;
   typedef enum logic [2:0] {
      OP_RESTART = 3'b000,
      OP_DUTY    = 3'b001,
      OP_RAMP    = 3'b010,
      OP_BRANCH  = 3'b011,
      OP_FINISH  = 3'b100,
      OP_SYNC    = 3'b101,
      OP_BAD     = 3'b110
   } spre_op_e;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RUN     = 2'b01,
      ST_HALTING = 2'b10
   } spre_run_e;

   typedef struct packed {
      spre_run_e   st;
      logic [5:0]  pc;
      logic [15:0] oreg;
      logic [15:0] cbuf;
      logic [15:0] act;
      logic        ov;
      logic        bv;
      logic        av;
      logic        ramp_on;
      logic [6:0]  steps;
      logic [5:0]  tmr;
      logic [7:0]  per;
      logic        per_on;
      logic [7:0]  ramp;
      logic [5:0]  loops;
      logic        loop_on;
      logic        sent;
      logic [2:0]  trig;
      logic        irq;
      logic        rirq_en;
      logic        pwm;
      logic        oe;
   } spre_chan_s;

   typedef struct packed {
      spre_chan_s [2:0]             ch;
      logic [2:0][63:0][15:0]       file;
      logic [1:0]                   sel_ch;
      logic [5:0]                   sel_addr;
      logic [31:0]                  rdata;
   } spre_state_s;

   typedef struct packed {
      logic [1:0] sync;
      logic       prev;
      logic [8:0] cnt;
      logic       slow;
      logic       d16;
      logic       d512;
   } spre_tick_s;

   // classify one script word
   function automatic spre_op_e spre_decode(input logic [15:0] w);
      if (w == 16'h0000)
         return OP_RESTART;
      if (!w[15])
         return (w[13:8] == 6'h00) ? OP_DUTY : OP_RAMP;
      if (w[14:13] == 2'b01)
         return OP_BRANCH;
      if (w[14:12] == 3'b100)
         return OP_FINISH;
      if (w[14:13] == 2'b11)
         return OP_SYNC;
      return OP_BAD;
   endfunction
endpackage

// ---- rtl/spre_tick_if.sv ----
// slow clock enables shared by the engines
`timescale 1ns/10ps
interface spre_tick_if;
   logic slow;   // one pulse per slow clock rise
   logic d16;    // slow divided by 16
   logic d512;   // slow divided by 512
   modport src (output slow, output d16, output d512);
   modport dst (input slow, input d16, input d512);
endinterface

// ---- rtl/spre_tick.sv ----
// slow clock synchroniser and prescaler
`timescale 1ns/10ps
`include "spre_defines.svh"
module spre_tick
   import spre_pkg::*;
(
   input  wire logic  i_clock,    // system clock
   input  wire logic  i_rstn,     // sync reset, low
   input  wire logic  i_slow_clk, // 32.768 kHz pin
   spre_tick_if.src   tk          // enable pulses
);
   spre_tick_s q;
   spre_tick_s d;

   // --------------------------------------------------------------
   // edge detect and divide
   // --------------------------------------------------------------
   always_comb begin
      d       = q;
      d.sync  = {q.sync[0], i_slow_clk};
      d.prev  = q.sync[1];
      d.slow  = q.sync[1] & ~q.prev;
      d.d16   = 1'b0;
      d.d512  = 1'b0;
      if (d.slow) begin
         d.cnt  = q.cnt + 9'h001;
         d.d16  = (q.cnt[3:0] == 4'(`SPRE_DIV_LO - 1));
         d.d512 = (q.cnt == 9'(`SPRE_DIV_HI - 1));
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end

   assign tk.slow = q.slow;
   assign tk.d16  = q.d16;
   assign tk.d512 = q.d512;
endmodule

// ---- rtl/spre_top.sv ----
// three script engines driving pulse-width outputs
// Behaviour
// - three outputs, each with its own autonomous script engine.
// - load, launch and halt each address one named channel only.
// - halt during a ramp takes effect once the ramp ends.
// - script words are 16 bits, written with a file address.
// - output register, buffer and active register form the queue.
// - output register moves to buffer only on a slow clock tick.
// - empty active takes buffer on a slow clock tick; buffer refills after.
// - queue is hidden from host; fetch runs after launch.
// - halt or finish stops the script; finish raises interrupt.
// - fixed 256-count period, programmable duty and ramping.
// - 8-bit period counter starts at first ramp, stops at finish.
// - output high while period count is at or below ramp count.
// - step rate from slow clock divided by 16 or 512.
// - each step moves ramp by one, saturating at FF or 00.
// - all requested steps elapse even after saturation.
// - optional interrupt after the last ramp step.
// - step time set by divider select and step interval.
// - step count reaches at most 127 per ramp.
// - all-zero word restarts at the first file word.
// - ramp word with zero interval loads the duty level.
// - ramp fields: divider, interval, direction, step count.
// - duty load takes the 8-bit level field.
// - finish with reset bit tristates, else output keeps level.
// - sync waits for all selected triggers, then clears them.
`timescale 1ns/10ps
`include "spre_defines.svh"
module spre_top
   import spre_pkg::*;
(
   input  wire logic        i_clock,      // 200 MHz clock
   input  wire logic        i_rstn,       // sync reset, low
   input  wire logic        i_slow_clk,   // 32.768 kHz pin
   input  wire logic [7:0]  i_addr,       // register byte address
   input  wire logic [31:0] i_wdata,      // write data
   input  wire logic        i_wr,         // write strobe
   input  wire logic        i_rd,         // read strobe
   output logic      [31:0] o_rdata,      // read data, next cycle
   output logic      [2:0]  o_pwm,        // modulated outputs
   output logic      [2:0]  o_pwm_oe,     // output enables
   output logic             o_host_irq_n  // interrupt, low
);
   spre_tick_if tk ();
   spre_state_s q;
   spre_state_s d;

   spre_tick u_tick (
      .i_clock    (i_clock),
      .i_rstn     (i_rstn),
      .i_slow_clk (i_slow_clk),
      .tk         (tk)
   );

   // --------------------------------------------------------------
   // host access, engines and queues
   // --------------------------------------------------------------
   always_comb begin
      logic [2:0][2:0] sent;
      logic        done;
      logic        jump;
      logic        stop;
      logic        ptick;
      logic [1:0]  cs;
      logic [15:0] w;
      logic [2:0]  wm;
      sent  = 9'h000;
      done  = 1'b0;
      jump  = 1'b0;
      stop  = 1'b0;
      ptick = 1'b0;
      cs    = i_wdata[1:0];
      w     = 16'h0000;
      wm    = 3'b000;
      d     = q;
      // host reads
      if (i_rd) begin
         d.rdata = 32'h0000_0000;
         unique case (i_addr)
            `SPRE_REG_ADDR:
               d.rdata = {22'h00_0000, q.sel_ch, 2'b00, q.sel_addr};
            `SPRE_REG_STAT:
               for (int c = 0; c < `SPRE_NCH; c++) begin
                  d.rdata[c] = (q.ch[c].st != ST_IDLE);
                  d.rdata[`SPRE_ST_IRQ + c] = q.ch[c].irq;
                  d.rdata[`SPRE_ST_RIRQ + c] = q.ch[c].rirq_en;
               end
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      // host writes
      if (i_wr) begin
         unique case (i_addr)
            `SPRE_REG_ADDR: begin
               d.sel_ch   = i_wdata[`SPRE_ADR_CH +: 2];
               d.sel_addr = i_wdata[5:0];
            end
            `SPRE_REG_WORD:
               if (q.sel_ch != 2'd3) begin
                  d.file[q.sel_ch][q.sel_addr] = i_wdata[15:0];
                  d.sel_addr = q.sel_addr + 6'h01;
               end
            `SPRE_REG_CTRL:
               if (cs != 2'd3) begin
                  d.ch[cs].rirq_en = i_wdata[`SPRE_CTL_RIRQ];
                  if (i_wdata[`SPRE_CTL_LAUNCH]) begin
                     d.ch[cs].st      = ST_RUN;
                     d.ch[cs].pc      = i_wdata[`SPRE_CTL_START +: 6];
                     d.ch[cs].ov      = 1'b0;
                     d.ch[cs].bv      = 1'b0;
                     d.ch[cs].av      = 1'b0;
                     d.ch[cs].ramp_on = 1'b0;
                     d.ch[cs].loop_on = 1'b0;
                     d.ch[cs].sent    = 1'b0;
                     d.ch[cs].oe      = 1'b1;
                  end else if (i_wdata[`SPRE_CTL_HALT] &&
                               q.ch[cs].st != ST_IDLE) begin
                     if (q.ch[cs].ramp_on)
                        d.ch[cs].st = ST_HALTING;
                     else begin
                        d.ch[cs].st = ST_IDLE;
                        d.ch[cs].ov = 1'b0;
                        d.ch[cs].bv = 1'b0;
                        d.ch[cs].av = 1'b0;
                     end
                  end
               end
            `SPRE_REG_STAT:
               for (int c = 0; c < `SPRE_NCH; c++)
                  if (i_wdata[`SPRE_ST_IRQ + c])
                     d.ch[c].irq = 1'b0;
            default: ;
         endcase
      end
      // one engine per channel, stepped on slow ticks
      for (int c = 0; c < `SPRE_NCH; c++) begin
         done  = 1'b0;
         jump  = 1'b0;
         stop  = 1'b0;
         w     = d.ch[c].act;
         wm    = w[9:7];
         ptick = w[14] ? tk.d512 : tk.d16;
         if (tk.slow && d.ch[c].av && d.ch[c].st != ST_IDLE) begin
            unique case (spre_decode(w))
               OP_RESTART: begin
                  done      = 1'b1;
                  jump      = 1'b1;
                  d.ch[c].pc = 6'h00;
               end
               OP_DUTY: begin
                  d.ch[c].ramp = w[7:0];
                  done = 1'b1;
               end
               OP_RAMP:
                  if (!d.ch[c].ramp_on) begin
                     d.ch[c].per_on = 1'b1;
                     if (w[6:0] == 7'h00)
                        done = 1'b1;
                     else begin
                        d.ch[c].ramp_on = 1'b1;
                        d.ch[c].steps   = w[6:0];
                        d.ch[c].tmr     = w[13:8];
                     end
                  end else if (ptick) begin
                     if (d.ch[c].tmr > 6'h01)
                        d.ch[c].tmr = d.ch[c].tmr - 6'h01;
                     else begin
                        d.ch[c].tmr = w[13:8];
                        if (!w[7] && d.ch[c].ramp != `SPRE_FULL)
                           d.ch[c].ramp = d.ch[c].ramp + 8'h01;
                        if (w[7] && d.ch[c].ramp != `SPRE_EMPTY)
                           d.ch[c].ramp = d.ch[c].ramp - 8'h01;
                        d.ch[c].steps = d.ch[c].steps - 7'h01;
                        if (d.ch[c].steps == 7'h00) begin
                           d.ch[c].ramp_on = 1'b0;
                           done = 1'b1;
                           if (d.ch[c].rirq_en)
                              d.ch[c].irq = 1'b1;
                           if (d.ch[c].st == ST_HALTING)
                              stop = 1'b1;
                        end
                     end
                  end
               OP_BRANCH: begin
                  done = 1'b1;
                  if (w[5:0] <= `SPRE_BR_LAST) begin
                     if (w[12:7] == 6'h00)
                        jump = 1'b1;
                     else if (!d.ch[c].loop_on) begin
                        d.ch[c].loops   = w[12:7] - 6'h02;
                        d.ch[c].loop_on = (w[12:7] != 6'h01);
                        jump            = (w[12:7] != 6'h01);
                     end else if (d.ch[c].loops == 6'h00)
                        d.ch[c].loop_on = 1'b0;
                     else begin
                        d.ch[c].loops = d.ch[c].loops - 6'h01;
                        jump          = 1'b1;
                     end
                     if (jump)
                        d.ch[c].pc = w[5:0];
                  end
               end
               OP_FINISH: begin
                  done           = 1'b1;
                  stop           = 1'b1;
                  d.ch[c].per_on = 1'b0;
                  d.ch[c].irq    = 1'b1;
                  if (w[11])
                     d.ch[c].oe = 1'b0;
               end
               OP_SYNC: begin
                  if (!d.ch[c].sent)
                     for (int k = 0; k < `SPRE_NCH; k++)
                        sent[k][c] = w[1 + k]; // target k, sender c
                  d.ch[c].sent = 1'b1;
                  if ((d.ch[c].trig & wm) == wm) begin
                     d.ch[c].trig = d.ch[c].trig & ~wm;
                     d.ch[c].sent = 1'b0;
                     done = 1'b1;
                  end
               end
               default: done = 1'b1;
            endcase
         end
         if (done)
            d.ch[c].av = 1'b0;
         if (jump || stop) begin
            d.ch[c].bv = 1'b0;
            d.ch[c].ov = 1'b0;
         end
         if (stop) begin
            d.ch[c].st = ST_IDLE;
            d.ch[c].av = 1'b0;
         end
         // queue moves in step with the slow clock
         if (tk.slow && d.ch[c].st != ST_IDLE) begin
            if (!d.ch[c].av && d.ch[c].bv) begin
               d.ch[c].act = d.ch[c].cbuf;
               d.ch[c].av  = 1'b1;
               d.ch[c].bv  = 1'b0;
            end
            if (!d.ch[c].bv && d.ch[c].ov) begin
               d.ch[c].cbuf = d.ch[c].oreg;
               d.ch[c].bv   = 1'b1;
               d.ch[c].ov   = 1'b0;
            end
         end
         // automatic fetch from the command file
         if (d.ch[c].st == ST_RUN && !d.ch[c].ov && !jump) begin
            d.ch[c].oreg = q.file[c][d.ch[c].pc];
            d.ch[c].ov   = 1'b1;
            d.ch[c].pc   = d.ch[c].pc + 6'h01;
         end
         // period counter and comparator
         if (tk.slow && d.ch[c].per_on)
            d.ch[c].per = d.ch[c].per + 8'h01;
         if (q.ch[c].per_on)
            d.ch[c].pwm = (q.ch[c].per <= q.ch[c].ramp);
         else
            d.ch[c].pwm = q.ch[c].ramp[7];
      end
      // triggers are held by the receiver until consumed
      for (int c = 0; c < `SPRE_NCH; c++)
         for (int k = 0; k < `SPRE_NCH; k++)
            if (sent[c][k] && q.ch[c].st != ST_IDLE)
               d.ch[c].trig[k] = 1'b1;
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end

   // outputs from flops
   always_comb begin
      o_rdata      = q.rdata;
      o_host_irq_n = 1'b1;
      for (int c = 0; c < `SPRE_NCH; c++) begin
         o_pwm[c]    = q.ch[c].pwm;
         o_pwm_oe[c] = q.ch[c].oe;
         if (q.ch[c].irq)
            o_host_irq_n = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // checks on channel 0
   // --------------------------------------------------------------
   spre_chan_s c0;
   spre_op_e   op0;
   assign c0  = q.ch[0];
   assign op0 = spre_decode(q.ch[0].act);

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   sequence fin_exec_s;
      tk.slow && c0.av && c0.st != ST_IDLE && op0 == OP_FINISH;
   endsequence

   cmp_out_a: assert property ($past(c0.per_on) |->
      c0.pwm == ($past(c0.per) <= $past(c0.ramp)))
      else $error("output does not follow comparator");
   up_sat_a: assert property (($past(c0.ramp_on) &&
      !$past(c0.act[7]) && $past(c0.ramp) == 8'hFF) |->
      c0.ramp == 8'hFF)
      else $error("ramp wrapped above full");
   halt_ramp_a: assert property ((c0.ramp_on ##1
      c0.st == ST_IDLE) |-> !c0.ramp_on)
      else $error("halt cut a ramp short");
   fin_irq_a: assert property (fin_exec_s |=>
      (c0.irq && c0.st == ST_IDLE ##1 !o_host_irq_n))
      else $error("finish did not stop or interrupt");
   fin_tri_a: assert property ((fin_exec_s and c0.act[11])
      |=> ##1 !o_pwm_oe[0])
      else $error("finish with reset bit left output on");
   per_hold_a: assert property ((!c0.per_on ##1
      !c0.per_on) |-> $stable(c0.per))
      else $error("period counter ran while stopped");
   pass_act_a: assert property ((tk.slow &&
      c0.st != ST_IDLE && !c0.av && c0.bv) |=> c0.av)
      else $error("buffer did not pass to active");
   buf_sync_a: assert property ($rose(c0.bv) |->
      $past(tk.slow))
      else $error("buffer loaded off the slow tick");
   sync_wait_a: assert property ((c0.av && op0 == OP_SYNC &&
      (c0.trig & c0.act[9:7]) != c0.act[9:7]) |=>
      (c0.av || c0.st == ST_IDLE))
      else $error("sync left before its triggers");
endmodule

// ---- test/spre_host_model.sv ----
// host side model: register bus master and slow clock source
`timescale 1ns/10ps
module spre_host_model (
   input  wire logic        i_clock,    // system clock
   input  wire logic [31:0] i_rdata,    // read data from device
   output logic      [7:0]  o_addr,     // byte address
   output logic      [31:0] o_wdata,    // write data
   output logic             o_wr,       // write strobe
   output logic             o_rd,       // read strobe
   output logic             o_slow_clk  // slow clock, eight system clocks
);
   // ------------------------------------------------------------
   // slow clock, free running, phase unrelated to system clock
   // ------------------------------------------------------------
   initial begin
      o_slow_clk = 1'b0;
      #3;
      forever #20 o_slow_clk = ~o_slow_clk;
   end

   // idle bus at time zero
   initial begin
      o_addr  = 8'h00;
      o_wdata = 32'h0000_0000;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   // one write cycle, strobe held for a single edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clock);
      o_addr  <= a;
      o_wdata <= v;
      o_wr    <= 1'b1;
      @(posedge i_clock);
      o_wr    <= 1'b0;
   endtask

   // one read cycle, data taken in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clock);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clock);
      o_rd   <= 1'b0;
      #1;
      v = i_rdata;
   endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the scripted pulse-width ramp engine
`timescale 1ns/10ps
`include "spre_defines.svh"
module tb;
   import spre_pkg::*;
   logic        i_clock;    // 200 MHz clock
   logic        i_rstn;     // sync reset, low
   logic [7:0]  addr;       // bus address
   logic [31:0] wdata;      // bus write data
   logic        wr;         // write strobe
   logic        rd;         // read strobe
   logic        slow;       // slow clock
   logic [31:0] rdata;      // bus read data
   logic [2:0]  pwm;        // modulated outputs
   logic [2:0]  pwm_oe;     // output enables
   logic        irq_n;      // interrupt, low
   logic [31:0] d;          // last read word
   logic [15:0] q[$];       // script under test
   int          failures;
   int          n_checks;
   int          seed;
   int          cyc;
   int          r1;
   int          r2;
   int          c0;
   int          n;

   spre_top uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_slow_clk(slow),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_pwm(pwm), .o_pwm_oe(pwm_oe),
      .o_host_irq_n(irq_n));
   spre_host_model host (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_slow_clk(slow));

   // ------------------------------------------------------------
   // clock and cycle count
   // ------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // checking helpers and reference model
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (failures == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(string nm, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_time(string nm, int lo, int hi, int g);
      n_checks++;
      if (g < lo || g > hi) begin
         failures++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // final level, slow ticks spent and tristate for a script
   function automatic void model(input logic [15:0] w[$], inout int lvl,
                                 output int tk, output bit ts);
      int k;
      tk = 0;
      ts = 1'b0;
      foreach (w[i]) begin
         k = w[i][6:0];
         if (w[i][15:13] == 3'b111)
            continue; // sync word leaves the level alone
         if (w[i][15]) begin
            ts = w[i][11];
            break;
         end else if (w[i][13:8] == 0)
            lvl = w[i][7:0];
         else begin
            tk += k * w[i][13:8] * (w[i][14] ? 512 : 16);
            if (w[i][7])
               lvl = (lvl > k) ? lvl - k : 0;
            else
               lvl = (lvl + k > 255) ? 255 : lvl + k;
         end
      end
   endfunction

   // bounded wait for the interrupt line to fall
   task automatic wait_low();
      int m;
      m = 0;
      while (irq_n !== 1'b0) begin
         @(posedge i_clock);
         #1;
         m++;
         if (m > 40000) begin
            failures++;
            report_and_stop();
         end
      end
   endtask

   // load a script, launch it, check the finished channel
   task automatic run_ch(input int ch, input int st, input int lvl0);
      int lvl;
      int tk;
      bit ts;
      int t0;
      lvl = lvl0;
      model(q, lvl, tk, ts);
      host.wr(`SPRE_REG_ADDR, 32'(ch << 8) | 32'(st));
      foreach (q[i])
         host.wr(`SPRE_REG_WORD, {16'h0000, q[i]});
      t0 = cyc;
      host.wr(`SPRE_REG_CTRL, 32'((st << 8) | 4 | ch));
      host.rd(`SPRE_REG_STAT, d);
      chk_reg("stat_running", 32'(1 << ch), d);
      wait_low();
      chk_time("run_cycles", tk * 8 - 128, tk * 8 + 400, cyc - t0);
      host.rd(`SPRE_REG_STAT, d);
      chk_reg("stat_finished", 32'(1 << (4 + ch)), d);
      chk_pin("pwm_oe", !ts, pwm_oe[ch]);
      if (!ts)
         chk_pin("pwm_level", lvl[7], pwm[ch]);
      host.wr(`SPRE_REG_STAT, 32'(1 << (4 + ch)));
      #1;
      chk_pin("irq_n_cleared", 1'b1, irq_n);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      failures = 0;
      n_checks = 0;
      seed = 12499;
      cyc = 0;
      i_rstn = 1'b0;
      repeat (2) @(posedge i_clock);
      i_rstn <= 1'b1;
      // reset state and register map
      #1;
      chk_pin("irq_n_reset", 1'b1, irq_n);
      chk_reg("oe_reset", 32'h0000_0000, 32'(pwm_oe));
      host.rd(`SPRE_REG_STAT, d);
      chk_reg("stat_reset", 32'h0000_0000, d);
      r1 = $random(seed) & 63;
      host.wr(`SPRE_REG_ADDR, 32'h0000_0100 | 32'(r1));
      host.rd(`SPRE_REG_ADDR, d);
      chk_reg("addr_readback", 32'h0000_0100 | 32'(r1), d);
      host.rd(8'h10, d);
      chk_reg("unmapped_read", 32'h0000_0000, d);
      // two back-to-back ramps up from zero, random step counts
      r1 = 100 + ($random(seed) & 15);
      r2 = 1 + ($random(seed) & 31);
      q = {16'h4000, 16'h0100 | 16'(r1), 16'h0100 | 16'(r2), 16'hC000};
      run_ch(1, 0, 0);
      // self trigger, saturation at full scale, then a 126-step ramp down
      q = {16'h40FF, 16'hE082, 16'h0105, 16'h01FE, 16'hC000};
      run_ch(0, 16, 0);
      // halt during a long ramp waits for the ramp to end
      q = {16'h40FF, 16'h0488, 16'hC800};
      host.wr(`SPRE_REG_ADDR, 32'h0000_0200);
      foreach (q[i])
         host.wr(`SPRE_REG_WORD, {16'h0000, q[i]});
      c0 = cyc;
      host.wr(`SPRE_REG_CTRL, 32'h0000_0006);
      repeat (300) @(posedge i_clock);
      host.wr(`SPRE_REG_CTRL, 32'h0000_000A);
      n = 0;
      d = 32'h0000_0004;
      while (d[2] !== 1'b0 && n < 3000) begin
         host.rd(`SPRE_REG_STAT, d);
         n++;
      end
      if (d[2] !== 1'b0) begin
         failures++;
         report_and_stop();
      end
      chk_time("halt_cycles", 4096 - 128, 4096 + 400, cyc - c0);
      chk_reg("stat_halted", 32'h0000_0000, d);
      chk_pin("irq_n_halted", 1'b1, irq_n);
      // a lone finish word with the reset bit tristates the output
      q = {16'hC800};
      run_ch(0, 2, 0);
      // ramp-done interrupt comes ahead of the finish word
      q = {16'h0102, 16'h0104, 16'hC000};
      host.wr(`SPRE_REG_ADDR, 32'h0000_0120);
      foreach (q[i])
         host.wr(`SPRE_REG_WORD, {16'h0000, q[i]});
      c0 = cyc;
      host.wr(`SPRE_REG_CTRL, 32'h0000_2015);
      wait_low();
      chk_time("ramp_irq_cycles", 128, 656, cyc - c0);
      host.rd(`SPRE_REG_STAT, d);
      chk_reg("stat_ramp_irq", 32'h0000_0222, d);
      report_and_stop();
   end
endmodule
